// ---- rtl/adcp_pkg.sv ----
package adcp_pkg;
    // Clock rate and converter timing.
    localparam int CLK_NS = 100;
    localparam int ACQ_NS = 3000;
    localparam int CONV_NS = 6000;
    localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 7;
    localparam logic [TMR_W-1:0] ACQ_LOAD = TMR_W'(ACQ_CYC - 1);
    localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYC - 1);
    // Data path shape.
    localparam int RES_W = 12;
    localparam int NCH = 8;
    localparam int FIFO_DEPTH = 8;
    // Serial frame positions, counted in rising serial-clock edges.
    localparam logic [4:0] CNT_IDLE = 5'h00;
    localparam logic [4:0] CNT_START = 5'h01;
    localparam logic [4:0] CNT_BYTE = 5'h07;
    localparam logic [4:0] CNT_INT_LOAD = 5'h08;
    localparam logic [4:0] CNT_INT_FIRST = 5'h09;
    localparam logic [4:0] CNT_EXT_STRB = 5'h0C;
    localparam logic [4:0] CNT_EXT_FIRST = 5'h0D;
    localparam logic [4:0] CNT_BITS = 5'h0C;
    localparam logic [4:0] CNT_MSB = 5'h0B;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    // Power and clock field codes.
    localparam logic [1:0] PD_INT = 2'h0;
    localparam logic [1:0] PD_STBY = 2'h2;
    localparam logic [1:0] PD_FULL = 2'h3;
    // Synchroniser reset pattern: shutdown pin idle high, toggles low.
    localparam logic [2:0] SYNC_RST = 3'h4;
    // Control byte without its start bit.
    typedef struct packed {
        logic [2:0] chan;
        logic range_select_bit;
        logic polarity_select_bit;
        logic [1:0] pd;
    } adcp_ctrl_t;
    localparam adcp_ctrl_t CTRL_RST = 7'h00;
    typedef enum {M_IDLE, M_ACQ, M_CONV} adcp_mst_t;
endpackage

// ---- rtl/adcp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcp_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] wdata,
    input wire logic wvalid,
    output logic wready,
    output logic [W-1:0] rdata,
    output logic rvalid,
    input wire logic rready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic wready_r, wready_nxt, rvalid_r, rvalid_nxt;
    logic push, pop;

    // Handshakes use registered flags, so full and empty are exact.
    assign push = wvalid && wready_r;
    assign pop = rready && rvalid_r;
    assign wready = wready_r;
    assign rvalid = rvalid_r;
    assign rdata = mem_r[rp_r];

    // Each entry takes the write data when the write pointer names it.
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
        assign mem_nxt[i] = (push && wp_r == AW'(i)) ? wdata : mem_r[i];
    end

    // Pointers, fill count and the flags derived from it.
    always_comb
    begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        wready_nxt = cnt_nxt != FULL_CNT;
        rvalid_nxt = cnt_nxt != '0;
    end

    // Storage carries no reset.
    always_ff @(posedge clk)
    begin
        mem_r <= mem_nxt;
    end

    // Control state registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            wready_r <= 1'b0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            wready_r <= wready_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Data input is sampled on each rising serial clock; host keeps it stable there.
// - With chip select high the data input is ignored entirely.
// - Data output changes on falling serial-clock edges, and clears to zero when chip select goes high.
// - Data output is not driven while chip select is high.
// - Internal clock mode drives the strobe low once the control byte ends.
// - Internal clock mode returns the strobe high when conversion completes.
// - External mode pulses the strobe high one clock before the first result bit.
// - External mode releases the strobe while chip select is high.
// - External mode conversion advances one step per serial clock.
// - Shutdown pin low forces full power-down whatever the written mode.
// - First one after select falls starts a byte: channel, range, polarity, mode.
// - Mode field: 00 internal, 01 external, 10 standby, 11 full power-down.
// - Acquisition starts once the control byte ends and lasts 30 system clocks, 3 us.
// - Channel field is a binary index selecting one of eight channels.
module adcp_top
    import adcp_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT_O,
    output logic DOUT_OE,
    output logic CONVERSION_STROBE_O,
    output logic CONVERSION_STROBE_OE,
    input wire logic SHUTDOWN_N_PIN,
    input wire logic [RES_W-1:0] SAMPLE_DATA,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    output logic [NCH-1:0] CHANNEL_EN,
    output logic [2:0] CHANNEL_SELECT_FIELD,
    output logic RANGE_SELECT_BIT,
    output logic POLARITY_SELECT_BIT,
    output logic [1:0] POWER_CLOCK_MODE_FIELD,
    output logic EXT_CLOCK_MODE,
    output logic STANDBY_POWER_DOWN,
    output logic FULL_POWER_DOWN,
    output logic TRACKING,
    output logic CONVERTING
);
    logic [1:0] rst_sync_r, rst_sync_nxt;
    logic sys_rst_n, frame_rst_n;
    logic [4:0] cnt_r, cnt_nxt;
    logic [5:0] sr_r, sr_nxt;
    logic [RES_W-1:0] res_r, res_nxt;
    adcp_ctrl_t ctrl_r, ctrl_nxt;
    logic ext_r, ext_nxt, req_tgl_r, req_tgl_nxt, take_tgl_r, take_tgl_nxt;
    logic dout_r, dout_nxt, dout_oe_r, dout_oe_nxt;
    logic conversion_strobe_r, conversion_strobe_nxt, strb_oe_r, strb_oe_nxt;
    logic [4:0] first_w, off_w, idx_w;
    logic [2:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
    logic req_ev, take_ev;
    adcp_mst_t mst_r, mst_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic int_strb_r, int_strb_nxt;
    logic [RES_W-1:0] word_r, word_nxt;
    logic word_vld_r, word_vld_nxt;
    logic [RES_W-1:0] fifo_data;
    logic fifo_vld, fifo_rdy;
    adcp_ctrl_t cfg_r, cfg_nxt;
    logic mext_r, mext_nxt, stby_r, stby_nxt, fpd_r, fpd_nxt;
    logic [NCH-1:0] chan_en_r, chan_en_nxt;
    logic track_r, track_nxt, conv_r, conv_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops; the frame logic is also held
    // in reset while chip select is high.
    always_comb
    begin
        rst_sync_nxt = {rst_sync_r[0], 1'b1};
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= rst_sync_nxt;
    end

    assign sys_rst_n = rst_sync_r[1];
    assign frame_rst_n = sys_rst_n && !CS_N;

    ////////////////////////////////////////////////////////////////////////////
    // Link side, rising edge: start detection, control byte and result load.
    always_comb
    begin
        cnt_nxt = cnt_r;
        sr_nxt = sr_r;
        res_nxt = res_r;
        ctrl_nxt = ctrl_r;
        ext_nxt = ext_r;
        req_tgl_nxt = req_tgl_r;
        take_tgl_nxt = take_tgl_r;
        if (cnt_r == CNT_IDLE)
        begin
            if (DIN)
                cnt_nxt = CNT_START;
        end
        else if (cnt_r != CNT_MAX)
            cnt_nxt = cnt_r + 5'h01;
        if (cnt_r != CNT_IDLE && cnt_r < CNT_BYTE)
            sr_nxt = {sr_r[4:0], DIN};
        if (cnt_r == CNT_BYTE)
        begin
            ctrl_nxt = {sr_r, DIN};
            req_tgl_nxt = !req_tgl_r;
            ext_nxt = sr_r[0] ? ext_r : DIN;
            // A power-down byte starts no conversion, so the held word stays put.
            if (ext_nxt && !sr_r[0])
            begin
                res_nxt = word_r;
                take_tgl_nxt = !take_tgl_r;
            end
        end
        if (cnt_r == CNT_INT_LOAD && !ext_r && !ctrl_r.pd[1])
        begin
            res_nxt = word_r;
            take_tgl_nxt = !take_tgl_r;
        end
    end

    // Frame state, cleared whenever chip select is high.
    always_ff @(posedge SCLK or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            cnt_r <= CNT_IDLE;
            sr_r <= 6'h00;
            res_r <= 12'h000;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            sr_r <= sr_nxt;
            res_r <= res_nxt;
        end
    end

    // State that outlives a frame and is read by the system side.
    always_ff @(posedge SCLK or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            ctrl_r <= CTRL_RST;
            ext_r <= 1'b0;
            req_tgl_r <= 1'b0;
            take_tgl_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ext_r <= ext_nxt;
            req_tgl_r <= req_tgl_nxt;
            take_tgl_r <= take_tgl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side, falling edge: result bits, external strobe and enables.
    always_comb
    begin
        first_w = ext_r ? CNT_EXT_FIRST : CNT_INT_FIRST;
        off_w = cnt_r - first_w;
        idx_w = CNT_MSB - off_w;
        dout_nxt = 1'b0;
        if (cnt_r >= first_w && off_w < CNT_BITS)
            dout_nxt = res_r[idx_w[3:0]];
        dout_oe_nxt = 1'b1;
        strb_oe_nxt = ext_r;
        conversion_strobe_nxt = ext_r && cnt_r == CNT_EXT_STRB;
    end

    always_ff @(negedge SCLK or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
            conversion_strobe_r <= 1'b0;
            strb_oe_r <= 1'b0;
        end
        else
        begin
            dout_r <= dout_nxt;
            dout_oe_r <= dout_oe_nxt;
            conversion_strobe_r <= conversion_strobe_nxt;
            strb_oe_r <= strb_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers for the shutdown pin and the two toggles;
    // a level counts once the second and third stages agree.
    always_comb
    begin
        lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
        req_ev = lvl_nxt[0] ^ lvl_r[0];
        take_ev = lvl_nxt[1] ^ lvl_r[1];
    end

    always_ff @(posedge MCLK or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
            lvl_r <= SYNC_RST;
        end
        else
        begin
            s1_r <= {SHUTDOWN_N_PIN, take_tgl_r, req_tgl_r};
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result words wait in the FIFO; one word is held for the link side.
    adcp_fifo #(
        .W(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(sys_rst_n),
        .wdata(SAMPLE_DATA),
        .wvalid(SAMPLE_VALID),
        .wready(SAMPLE_READY),
        .rdata(fifo_data),
        .rvalid(fifo_vld),
        .rready(fifo_rdy)
    );

    assign fifo_rdy = !word_vld_r;

    // Channel enables, one per input.
    for (genvar i = 0; i < NCH; i++)
    begin : g_chan
        assign chan_en_nxt[i] = cfg_nxt.chan == 3'(i);
    end

    // Configuration decode and the internally timed conversion.
    always_comb
    begin
        cfg_nxt = req_ev ? ctrl_r : cfg_r;
        mext_nxt = mext_r;
        if (req_ev && !ctrl_r.pd[1])
            mext_nxt = ctrl_r.pd[0];
        stby_nxt = lvl_r[2] && cfg_nxt.pd == PD_STBY;
        fpd_nxt = !lvl_r[2] || cfg_nxt.pd == PD_FULL;
        mst_nxt = mst_r;
        tmr_nxt = tmr_r;
        int_strb_nxt = int_strb_r;
        word_nxt = word_r;
        word_vld_nxt = word_vld_r;
        if (take_ev)
            word_vld_nxt = 1'b0;
        if (fifo_vld && !word_vld_r)
        begin
            word_nxt = fifo_data;
            word_vld_nxt = 1'b1;
        end
        unique case (mst_r)
            M_IDLE:
                if (req_ev && ctrl_r.pd == PD_INT && lvl_r[2])
                begin
                    mst_nxt = M_ACQ;
                    tmr_nxt = ACQ_LOAD;
                    int_strb_nxt = 1'b0;
                end
            M_ACQ:
                if (tmr_r == '0)
                begin
                    mst_nxt = M_CONV;
                    tmr_nxt = CONV_LOAD;
                end
                else
                    tmr_nxt = tmr_r - 1'b1;
            M_CONV:
                if (tmr_r != '0)
                    tmr_nxt = tmr_r - 1'b1;
                else if (word_vld_r)
                begin
                    mst_nxt = M_IDLE;
                    int_strb_nxt = 1'b1;
                end
        endcase
        track_nxt = mst_nxt == M_ACQ;
        conv_nxt = mst_nxt == M_CONV;
    end

    always_ff @(posedge MCLK or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            cfg_r <= CTRL_RST;
            mext_r <= 1'b0;
            stby_r <= 1'b0;
            fpd_r <= 1'b0;
            chan_en_r <= 8'h01;
            mst_r <= M_IDLE;
            tmr_r <= '0;
            int_strb_r <= 1'b1;
            word_r <= 12'h000;
            word_vld_r <= 1'b0;
            track_r <= 1'b0;
            conv_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            mext_r <= mext_nxt;
            stby_r <= stby_nxt;
            fpd_r <= fpd_nxt;
            chan_en_r <= chan_en_nxt;
            mst_r <= mst_nxt;
            tmr_r <= tmr_nxt;
            int_strb_r <= int_strb_nxt;
            word_r <= word_nxt;
            word_vld_r <= word_vld_nxt;
            track_r <= track_nxt;
            conv_r <= conv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins; the strobe pin picks its source by clock mode.
    assign DOUT_O = dout_r;
    assign DOUT_OE = dout_oe_r;
    assign CONVERSION_STROBE_O = ext_r ? conversion_strobe_r : int_strb_r;
    assign CONVERSION_STROBE_OE = ext_r ? strb_oe_r : 1'b1;
    assign CHANNEL_EN = chan_en_r;
    assign CHANNEL_SELECT_FIELD = cfg_r.chan;
    assign RANGE_SELECT_BIT = cfg_r.range_select_bit;
    assign POLARITY_SELECT_BIT = cfg_r.polarity_select_bit;
    assign POWER_CLOCK_MODE_FIELD = cfg_r.pd;
    assign EXT_CLOCK_MODE = mext_r;
    assign STANDBY_POWER_DOWN = stby_r;
    assign FULL_POWER_DOWN = fpd_r;
    assign TRACKING = track_r;
    assign CONVERTING = conv_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the system side.
    sequence s_acq_end;
        mst_r == M_ACQ && tmr_r == '0;
    endsequence
    sequence s_conv_begin;
        mst_r == M_CONV && tmr_r == CONV_LOAD;
    endsequence
    a_acq_to_conv: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        s_acq_end |=> s_conv_begin) else $error("Acquisition end not followed by conversion.");
    a_strobe_fall: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        (mst_r == M_IDLE && mst_nxt == M_ACQ) |=> (tmr_r == ACQ_LOAD && !int_strb_r))
        else $error("Strobe not low at conversion start.");
    a_strobe_rise: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        $rose(int_strb_r) |-> ($past(mst_r) == M_CONV && $past(word_vld_r)))
        else $error("Strobe rose before conversion end.");
    a_shutdown_n_pin_full_pd: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        !lvl_r[2] |=> (FULL_POWER_DOWN && !STANDBY_POWER_DOWN))
        else $error("Shutdown did not force full power-down.");
    a_chan_onehot: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        chan_en_r == (8'h01 << cfg_r.chan)) else $error("Channel enable mismatch.");
    a_mode_kept: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        (req_ev && ctrl_r.pd[1]) |=> $stable(mext_r)) else $error("Power mode changed clock mode.");
    // Checks on the link side.
    a_no_false_start: assert property (@(posedge SCLK) disable iff (!frame_rst_n)
        (cnt_r == CNT_IDLE && !DIN) |=> cnt_r == CNT_IDLE) else $error("Zero taken as start.");
    a_ext_strobe_one: assert property (@(negedge SCLK) disable iff (!frame_rst_n)
        $rose(conversion_strobe_r) |=> !conversion_strobe_r) else $error("External strobe longer than one clock.");
    a_dout_hiz: assert property (@(negedge SCLK) disable iff (!sys_rst_n)
        CS_N |-> (!dout_oe_r && !strb_oe_r)) else $error("Output driven with select high.");
    a_msb_first: assert property (@(negedge SCLK) disable iff (!frame_rst_n)
        (cnt_r == first_w) |=> (dout_r == res_r[RES_W-1])) else $error("First bit not MSB.");
endmodule
`default_nettype wire

// ---- sim/adcp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Serial host model: clock idles low, data changes after each fall and is sampled at each rise.
module adcp_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic strb_o,
    input wire logic strb_oe
);
    localparam realtime HALF = 7.5;
    // A released strobe pin reads as the inverse of its last level.
    wire strb_pin = strb_oe ? strb_o : ~strb_o;
    logic [31:0] strb_seen;
    logic [11:0] word;
    int wait_steps;
    logic timed_out;

    // Idle state: select high, clock standing low.
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One serial clock; the strobe and the result bit are taken at the rise.
    task automatic pulse(input int k, input int first);
        #HALF sclk = 1'b1;
        strb_seen[k] = strb_pin;
        if (k >= first)
            word = {word[10:0], dout_oe ? dout_o : ~word[0]};
        #HALF sclk = 1'b0;
    endtask

    // Hold off the result read until the strobe has fallen and risen again.
    task automatic strobe_wait();
        int t;
        t = 0;
        while (strb_pin === 1'b1 && t < 40)
        begin
            #100;
            t++;
        end
        timed_out = (t >= 40);
        while (strb_pin !== 1'b1 && wait_steps < 400)
        begin
            #100;
            wait_steps++;
        end
        if (wait_steps >= 400)
            timed_out = 1'b1;
    endtask

    // One frame: mode 0 internal conversion, 1 external conversion, 2 control byte only.
    task automatic frame(input logic [7:0] ctrl, input int lead, input int mode);
        int n;
        n = (mode == 1) ? 25 : ((mode == 0) ? 21 : 8);
        word = 12'h000;
        strb_seen = '0;
        timed_out = 1'b0;
        wait_steps = 0;
        cs_n = 1'b0;
        din = 1'b0;
        repeat (lead) pulse(0, 99);
        for (int k = 1; k <= n; k++)
        begin
            din = (k <= 8) ? ctrl[8-k] : ~din;
            if (k == 9 && mode == 0)
                strobe_wait();
            pulse(k, n - 11);
        end
        #HALF cs_n = 1'b1;
        din = ~din;
    endtask

    // Clocks with select high; none of these bits may be taken.
    task automatic stray(input int cnt);
        din = 1'b1;
        repeat (cnt) pulse(0, 99);
        din = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/adcp_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcp_top_tb
    import adcp_pkg::*;
;
    logic mclk, rst_n, sd_pin_n, s_valid, ext_exp, took;
    logic [RES_W-1:0] s_data;
    logic [RES_W-1:0] exp_q[$];
    wire sclk, cs_n, din, dout_o, dout_oe, strb_o, strb_oe, s_ready, range_select_bit, polarity_select_bit;
    wire ext_mode, stby, full, tracking, converting;
    wire [2:0] chan;
    wire [1:0] pd;
    wire [NCH-1:0] ch_en;
    int n_mismatch, tests_run, lows;

    adcp_top adcp_top_inst (
        .MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .DOUT_O(dout_o), .DOUT_OE(dout_oe), .CONVERSION_STROBE_O(strb_o),
        .CONVERSION_STROBE_OE(strb_oe), .SHUTDOWN_N_PIN(sd_pin_n), .SAMPLE_DATA(s_data),
        .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .CHANNEL_EN(ch_en),
        .CHANNEL_SELECT_FIELD(chan), .RANGE_SELECT_BIT(range_select_bit), .POLARITY_SELECT_BIT(polarity_select_bit),
        .POWER_CLOCK_MODE_FIELD(pd), .EXT_CLOCK_MODE(ext_mode), .STANDBY_POWER_DOWN(stby),
        .FULL_POWER_DOWN(full), .TRACKING(tracking), .CONVERTING(converting)
    );

    adcp_host adcp_host_inst (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
        .strb_o(strb_o), .strb_oe(strb_oe)
    );

    // System clock at 10 MHz.
    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one seen value against its expectation.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Offer one word for one clock; it counts only if the buffer was ready.
    task automatic push(input logic [RES_W-1:0] w, output logic ok);
        @(negedge mclk);
        ok = s_ready;
        s_data = w;
        s_valid = s_ready;
        @(negedge mclk);
        s_valid = 1'b0;
        if (ok)
            exp_q.push_back(w);
    endtask

    // One frame through the host, then the decoded fields, enables and, unless mode 2, the result are checked.
    task automatic conv(input logic [7:0] ctrl, input int lead, input int mode);
        if (ctrl[1:0] == PD_INT)
            ext_exp = 1'b0;
        else if (ctrl[1:0] == 2'h1)
            ext_exp = 1'b1;
        adcp_host_inst.frame(ctrl, lead, mode);
        settle(12);
        check("chan", 16'(chan), 16'(ctrl[6:4]));
        check("chan_en", 16'(ch_en), 16'(8'h01 << ctrl[6:4]));
        check("rng_bip_pd", 16'({range_select_bit, polarity_select_bit, pd}), 16'(ctrl[3:0]));
        check("ext_mode", 16'(ext_mode), 16'(ext_exp));
        check("standby", 16'(stby), 16'(ctrl[1:0] == PD_STBY && sd_pin_n));
        check("full_pd", 16'(full), 16'(ctrl[1:0] == PD_FULL || !sd_pin_n));
        check("dout_oe", 16'(dout_oe), 16'h0000);
        check("strobe_oe", 16'(strb_oe), 16'(!ext_exp));
        if (mode != 2)
            check("result", 16'(adcp_host_inst.word), 16'(exp_q.pop_front()));
        if (mode == 0)
        begin
            check("strobe_to", 16'(adcp_host_inst.timed_out), 16'h0000);
            check("conv_len", 16'(adcp_host_inst.wait_steps >= ACQ_CYC + CONV_CYC - 1
                && adcp_host_inst.wait_steps <= ACQ_CYC + CONV_CYC + 10), 16'h0001);
            check("busy", 16'({tracking, converting}), 16'h0000);
        end
        if (mode == 1)
            check("ext_strobe", 16'(adcp_host_inst.strb_seen[14:12]), 16'h0002);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, buffer fill, all channels, both clock modes, power modes.
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        sd_pin_n = 1'b1;
        s_valid = 1'b0;
        s_data = '0;
        ext_exp = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        settle(2);
        check("rst_chan_en", 16'(ch_en), 16'h0001);
        check("rst_dout_oe", 16'(dout_oe), 16'h0000);
        check("rst_strobe", 16'({strb_o, strb_oe}), 16'h0003);
        rst_n = 1'b1;
        settle(6);
        adcp_host_inst.stray(6);
        check("stray_oe", 16'(dout_oe), 16'h0000);
        took = 1'b1;
        for (int i = 0; i < 16 && took; i++)
            push(RES_W'(12'hA50 + i), took);
        check("fifo_full", 16'({took, s_ready}), 16'h0000);
        for (int i = 0; i < NCH; i++)
            conv({1'b1, 3'(i), 1'(i), 1'(i >> 1), PD_INT}, i % 3, 0);
        check("fifo_drain", 16'(s_ready), 16'h0001);
        for (int i = 0; i < 4; i++)
            push(RES_W'(12'h5C0 + i), took);
        settle(20);
        conv(8'hD9, 0, 1);
        conv(8'hA2, 0, 2);
        conv(8'hF7, 0, 2);
        conv(8'h85, 0, 1);
        conv(8'hC8, 0, 0);
        sd_pin_n = 1'b0;
        settle(6);
        conv(8'hB0, 0, 2);
        lows = 0;
        repeat (120)
        begin
            @(negedge mclk);
            if (strb_o !== 1'b1)
                lows++;
        end
        check("sd_block", 16'(lows), 16'h0000);
        sd_pin_n = 1'b1;
        settle(6);
        conv(8'h94, 0, 0);
        report_and_stop();
    end

    // Cuts a hung run short and counts it as a mismatch.
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
